// ### src/ps_config_loader.sv
// Passive serial configuration receiver with power-on delay,
// reset/config/init sequencing, chain enables and a register port.
// Assumes all pins arrive asynchronously; open-drain lines are
// resolved outside from the output enables (low = driving low).
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ns

module ps_config_loader #(
   parameter int unsigned POR_LONG_CYCLES = ps_loader_pkg::POR_LONG_CYCLES,
   parameter int unsigned POR_SHORT_CYCLES = ps_loader_pkg::POR_SHORT_CYCLES
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   // Configuration pins
   input wire logic por_delay_select_i,
   input wire logic io_weak_pull_n_i,
   input wire logic config_request_i,
   input wire logic serial_config_clock_i,
   input wire logic serial_config_in_i,
   input wire logic chain_enable_in_n_i,
   output logic chain_enable_out_n_o,
   input wire logic status_line_i,
   output logic status_line_o,
   output logic status_line_oe_n_o,
   input wire logic load_done_i,
   output logic load_done_o,
   output logic load_done_oe_n_o,
   // Device-side controls
   output logic user_io_hiz_o,
   output logic weak_pull_en_o,
   output logic user_mode_o,
   output logic [31:0] config_word_o,
   output logic config_word_valid_o,
   // Register port
   input wire logic [ps_loader_pkg::ADDR_W-1:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   output logic irq_o
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      ps_loader_pkg::load_state_e state;
      logic [ps_loader_pkg::POR_CNT_W-1:0] por_cnt;
      logic [31:0] bit_cnt;
      logic [31:0] shift;
      logic [4:0] word_bits;
      logic [31:0] word;
      logic word_valid;
      logic preamble_ok;
      logic err;
      logic [1:0] osc_cnt;
      logic [7:0] init_cnt;
      logic sclk_prev;
      logic status_drive_low;
      logic done_release;
      logic chain_out_n;
      logic hiz;
      logic pull_en;
      logic user_mode;
      logic [31:0] length;
      logic [3:0] irq_stat;
      logic [3:0] irq_mask;
      logic irq;
      logic [31:0] rdata;
   } loader_s;

   loader_s q;
   loader_s d;

   logic [ps_loader_pkg::PIN_N-1:0] pins_raw;
   logic [ps_loader_pkg::PIN_N-1:0] pins_s;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   always_comb begin
      pins_raw = '0;
      pins_raw[ps_loader_pkg::PIN_REQ] = config_request_i;
      pins_raw[ps_loader_pkg::PIN_STATUS] = status_line_i;
      pins_raw[ps_loader_pkg::PIN_DONE] = load_done_i;
      pins_raw[ps_loader_pkg::PIN_SCLK] = serial_config_clock_i;
      pins_raw[ps_loader_pkg::PIN_SDATA] = serial_config_in_i;
      pins_raw[ps_loader_pkg::PIN_CEN_N] = chain_enable_in_n_i;
      pins_raw[ps_loader_pkg::PIN_POR_DELAY_SELECT] = por_delay_select_i;
      pins_raw[ps_loader_pkg::PIN_PULL_N] = io_weak_pull_n_i;
   end

   pin_sync #(
      .WIDTH(ps_loader_pkg::PIN_N)
   ) u_pin_sync (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .pins_i(pins_raw),
      .pins_o(pins_s)
   );

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   logic req_s;
   logic stat_s;
   logic done_s;
   logic sclk_rise;
   logic sdata_s;
   logic cen_n_s;
   logic osc_tick;
   logic [ps_loader_pkg::POR_CNT_W-1:0] por_limit;
   logic [3:0] events;
   logic [3:0] irq_clear;
   logic [31:0] next_shift;
   logic [31:0] status_word;

   // Named views of the synchronised pins
   // Lanes reset low while an idle serial clock sits high, so one
   // false rising edge follows reset; it falls in power-on, unused
   always_comb begin
      req_s = pins_s[ps_loader_pkg::PIN_REQ];
      stat_s = pins_s[ps_loader_pkg::PIN_STATUS];
      done_s = pins_s[ps_loader_pkg::PIN_DONE];
      sdata_s = pins_s[ps_loader_pkg::PIN_SDATA];
      cen_n_s = pins_s[ps_loader_pkg::PIN_CEN_N];
      sclk_rise = pins_s[ps_loader_pkg::PIN_SCLK] & ~q.sclk_prev;
      osc_tick = (q.osc_cnt == ps_loader_pkg::OSC_DIV_MAX);
   end

   // Power-on delay chosen by the delay-select strap
   always_comb begin
      if (pins_s[ps_loader_pkg::PIN_POR_DELAY_SELECT]) begin
         por_limit = ps_loader_pkg::POR_CNT_W'(POR_SHORT_CYCLES - 1);
      end else begin
         por_limit = ps_loader_pkg::POR_CNT_W'(POR_LONG_CYCLES - 1);
      end
   end

   // Status register image
   always_comb begin
      status_word = '0;
      status_word[ps_loader_pkg::ST_STATE_LSB +: 3] = q.state;
      status_word[ps_loader_pkg::ST_ERROR] = q.err;
      status_word[ps_loader_pkg::ST_DONE_LINE] = done_s;
      status_word[ps_loader_pkg::ST_STATUS_LINE] = stat_s;
      status_word[ps_loader_pkg::ST_CHAIN_OUT_N] = q.chain_out_n;
   end

   // Sequencer, shift register, divider, register port
   always_comb begin
      d = q;
      events = '0;
      irq_clear = '0;
      next_shift = {q.shift[30:0], sdata_s};
      d.word_valid = 1'b0;
      d.rdata = '0;
      d.sclk_prev = pins_s[ps_loader_pkg::PIN_SCLK];
      // Internal oscillator stand-in for initialization
      d.osc_cnt = q.osc_cnt + 2'h1;

      case (q.state)
         ps_loader_pkg::ST_POR: begin
            // Held in reset, status low, pins floating
            d.status_drive_low = 1'b1;
            d.hiz = 1'b1;
            d.pull_en = 1'b0;
            if (q.por_cnt >= por_limit) begin
               d.state = ps_loader_pkg::ST_RESET;
            end else begin
               d.por_cnt = q.por_cnt + 1'b1;
            end
         end
         ps_loader_pkg::ST_RESET: begin
            d.hiz = 1'b1;
            d.chain_out_n = 1'b1;
            d.done_release = 1'b0;
            d.bit_cnt = '0;
            d.word_bits = '0;
            d.preamble_ok = 1'b0;
            // Request high lets go of the status line
            d.status_drive_low = ~req_s;
            if (req_s && stat_s) begin
               d.state = ps_loader_pkg::ST_CONFIG;
               d.err = 1'b0;
               events[ps_loader_pkg::IRQ_START] = 1'b1;
            end
         end
         ps_loader_pkg::ST_CONFIG: begin
            if (!req_s || !stat_s) begin
               d.state = ps_loader_pkg::ST_RESET;
            end else if (sclk_rise && !cen_n_s) begin
               // One bit per serial clock rising edge while enabled
               d.shift = next_shift;
               d.bit_cnt = q.bit_cnt + 32'h1;
               d.word_bits = q.word_bits + 5'h01;
               if (q.word_bits == 5'h1F) begin
                  d.word = next_shift;
                  d.word_valid = 1'b1;
                  if (!q.preamble_ok && next_shift != ps_loader_pkg::PREAMBLE) begin
                     d.err = 1'b1;
                     d.status_drive_low = 1'b1;
                     d.state = ps_loader_pkg::ST_ERROR_HOLD;
                     events[ps_loader_pkg::IRQ_ERROR] = 1'b1;
                  end
                  d.preamble_ok = 1'b1;
               end
               // Completion only when the word above raised no error
               if ((q.bit_cnt + 32'h1) == q.length && d.state == ps_loader_pkg::ST_CONFIG) begin
                  d.done_release = 1'b1;
                  d.chain_out_n = 1'b0;
                  d.state = ps_loader_pkg::ST_WAIT_DONE;
                  events[ps_loader_pkg::IRQ_LOADED] = 1'b1;
               end
            end
         end
         ps_loader_pkg::ST_WAIT_DONE: begin
            if (!req_s || !stat_s) begin
               d.state = ps_loader_pkg::ST_RESET;
            end else if (done_s) begin
               // Shared line high: whole chain is loaded
               d.state = ps_loader_pkg::ST_INIT;
               d.init_cnt = '0;
            end
         end
         ps_loader_pkg::ST_INIT: begin
            if (!req_s || !stat_s) begin
               d.state = ps_loader_pkg::ST_RESET;
            end else if (osc_tick) begin
               d.init_cnt = q.init_cnt + 8'h01;
               // Free-running divider: first tick lands 1 to 4 cycles in
               if (q.init_cnt == ps_loader_pkg::INIT_TICKS - 8'h01) begin
                  d.state = ps_loader_pkg::ST_USER;
                  d.hiz = 1'b0;
                  d.user_mode = 1'b1;
                  events[ps_loader_pkg::IRQ_USER] = 1'b1;
               end
            end
         end
         ps_loader_pkg::ST_USER: begin
            // Configured: only a dropped request restarts the device
            if (!req_s) begin
               d.state = ps_loader_pkg::ST_RESET;
               d.hiz = 1'b1;
               d.user_mode = 1'b0;
            end
         end
         ps_loader_pkg::ST_ERROR_HOLD: begin
            // Keep the chain halted until the host drops the request
            d.status_drive_low = 1'b1;
            if (!req_s) begin
               d.state = ps_loader_pkg::ST_RESET;
            end
         end
         default: begin
            d.state = ps_loader_pkg::ST_POR;
         end
      endcase

      // Pull-ups on after power-on until user mode, unless the pull strap disables them
      d.pull_en = (d.state != ps_loader_pkg::ST_POR) && (d.state != ps_loader_pkg::ST_USER)
         && !pins_s[ps_loader_pkg::PIN_PULL_N];

      // Register writes
      // Read-only and unmapped offsets leave state untouched
      if (reg_wr_i) begin
         case (reg_addr_i)
            ps_loader_pkg::REG_LENGTH: d.length = reg_wdata_i;
            ps_loader_pkg::REG_IRQ_STAT: irq_clear = reg_wdata_i[3:0];
            ps_loader_pkg::REG_IRQ_MASK: d.irq_mask = reg_wdata_i[3:0];
            default: d.length = d.length;
         endcase
      end

      // Register reads, data valid the following cycle
      // Reads have no side effects; events clear only by a write
      if (reg_rd_i) begin
         case (reg_addr_i)
            ps_loader_pkg::REG_LENGTH: d.rdata = q.length;
            ps_loader_pkg::REG_STATUS: d.rdata = status_word;
            ps_loader_pkg::REG_IRQ_STAT: d.rdata = {28'h0000000, q.irq_stat};
            ps_loader_pkg::REG_IRQ_MASK: d.rdata = {28'h0000000, q.irq_mask};
            ps_loader_pkg::REG_BIT_COUNT: d.rdata = q.bit_cnt;
            ps_loader_pkg::REG_LAST_WORD: d.rdata = q.word;
            default: d.rdata = '0;
         endcase
      end

      // Sticky events; a new event beats a clear
      d.irq_stat = (q.irq_stat & ~irq_clear) | events;
      d.irq = |(d.irq_stat & d.irq_mask);
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
         q.state <= ps_loader_pkg::ST_POR;
         q.status_drive_low <= 1'b1;
         q.hiz <= 1'b1;
         q.chain_out_n <= 1'b1;
         q.length <= ps_loader_pkg::LENGTH_RST;
         q.irq_mask <= ps_loader_pkg::IRQ_MASK_RST;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------
   // Outputs, all from flip-flops or constants
   // ----------------------------------------
   assign status_line_o = 1'b0;
   assign status_line_oe_n_o = ~q.status_drive_low;
   assign load_done_o = 1'b0;
   assign load_done_oe_n_o = q.done_release;
   assign chain_enable_out_n_o = q.chain_out_n;
   assign user_io_hiz_o = q.hiz;
   assign weak_pull_en_o = q.pull_en;
   assign user_mode_o = q.user_mode;
   assign config_word_o = q.word;
   assign config_word_valid_o = q.word_valid;
   assign reg_rdata_o = q.rdata;
   assign irq_o = q.irq;

endmodule

// ### src/ps_loader_pkg.sv
// Constants, register map and types for the passive serial loader.
// Assumes a 25 MHz system clock and a 32-bit plain register port.
package ps_loader_pkg;

   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned POR_LONG_MS = 100;
   localparam int unsigned POR_SHORT_MS = 12;
   localparam int unsigned POR_LONG_CYCLES = (POR_LONG_MS * (CLK_HZ / 1000));
   localparam int unsigned POR_SHORT_CYCLES = (POR_SHORT_MS * (CLK_HZ / 1000));
   localparam int unsigned POR_CNT_W = 22;
   // Internal oscillator tick: one enable per 4 system cycles (OSC_DIV_MAX + 1)
   localparam logic [1:0] OSC_DIV_MAX = 2'h3;
   localparam logic [7:0] INIT_TICKS = 8'h40;

   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam int unsigned ADDR_W = 5;
   localparam logic [4:0] REG_LENGTH = 5'h00;
   localparam logic [4:0] REG_STATUS = 5'h04;
   localparam logic [4:0] REG_IRQ_STAT = 5'h08;
   localparam logic [4:0] REG_IRQ_MASK = 5'h0C;
   localparam logic [4:0] REG_BIT_COUNT = 5'h10;
   localparam logic [4:0] REG_LAST_WORD = 5'h14;

   // Reset values
   localparam logic [31:0] LENGTH_RST = 32'h0000_1000;
   localparam logic [3:0] IRQ_MASK_RST = 4'h0;
   // Leading word expected at the head of every stream
   localparam logic [31:0] PREAMBLE = 32'hA5A5_5A5A;

   // Interrupt bit positions
   localparam int unsigned IRQ_START = 0;
   localparam int unsigned IRQ_LOADED = 1;
   localparam int unsigned IRQ_ERROR = 2;
   localparam int unsigned IRQ_USER = 3;

   // Status register field positions
   localparam int unsigned ST_STATE_LSB = 0;
   localparam int unsigned ST_ERROR = 4;
   localparam int unsigned ST_DONE_LINE = 5;
   localparam int unsigned ST_STATUS_LINE = 6;
   localparam int unsigned ST_CHAIN_OUT_N = 7;

   // Synchroniser lanes
   localparam int unsigned PIN_N = 8;
   localparam int unsigned PIN_REQ = 0;
   localparam int unsigned PIN_STATUS = 1;
   localparam int unsigned PIN_DONE = 2;
   localparam int unsigned PIN_SCLK = 3;
   localparam int unsigned PIN_SDATA = 4;
   localparam int unsigned PIN_CEN_N = 5;
   localparam int unsigned PIN_POR_DELAY_SELECT = 6;
   localparam int unsigned PIN_PULL_N = 7;

   typedef enum logic [2:0] {
      ST_POR,
      ST_RESET,
      ST_CONFIG,
      ST_WAIT_DONE,
      ST_INIT,
      ST_USER,
      ST_ERROR_HOLD
   } load_state_e;

endpackage

// ### src/pin_sync.sv
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes each lane is an independent level from outside clk_sys_i.
`timescale 1ns/1ns
module pin_sync #(
   parameter int unsigned WIDTH = 8
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic [WIDTH-1:0] pins_i,
   output logic [WIDTH-1:0] pins_o
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_s;

   sync_s q;
   sync_s d;

   // ----------------------------------------
   // Per-lane two flip-flop chain
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_lane
         // First stage feeds only the second stage
         always_comb begin
            d.meta[i] = pins_i[i];
            d.stable[i] = q.meta[i];
         end
      end
   endgenerate

   // State register
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign pins_o = q.stable;

endmodule

// ### test/ps_config_loader_asserts.sv
// Concurrent checks on the loader's pins and register port.
// Assumes it is bound into ps_config_loader and sees only its ports.
`timescale 1ns/1ns
module ps_config_loader_asserts #(
   parameter int unsigned POR_LONG_CYCLES = 50,
   parameter int unsigned POR_SHORT_CYCLES = 20
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic por_delay_select_i,
   input wire logic io_weak_pull_n_i,
   input wire logic config_request_i,
   input wire logic chain_enable_in_n_i,
   input wire logic chain_enable_out_n_o,
   input wire logic status_line_i,
   input wire logic status_line_oe_n_o,
   input wire logic load_done_i,
   input wire logic load_done_oe_n_o,
   input wire logic user_io_hiz_o,
   input wire logic weak_pull_en_o,
   input wire logic user_mode_o,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o
);
   logic [31:0] age_q;
   logic [31:0] age_d;
   // Cycles since reset release, saturating
   always_comb begin
      age_d = (age_q == 32'hFFFF_FFFF) ? age_q : age_q + 32'h1;
   end
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         age_q <= 32'h0;
      end else begin
         age_q <= age_d;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_done_seen;
      $rose(load_done_i) && config_request_i;
   endsequence
   sequence s_user_entry;
      ##[250:270] user_mode_o;
   endsequence
   a_por_holds_pins: assert property (
      age_q < (por_delay_select_i ? POR_SHORT_CYCLES : POR_LONG_CYCLES)
      |-> !status_line_oe_n_o && user_io_hiz_o && !weak_pull_en_o) else $error("left power-on early");
   a_hiz_before_user: assert property (
      !user_mode_o |-> user_io_hiz_o) else $error("user pins driven before user mode");
   a_pull_follows_pin: assert property (
      io_weak_pull_n_i [*6] |=> !weak_pull_en_o) else $error("pull-ups on while disabled");
   a_request_low_reset: assert property (
      !config_request_i [*6] |=> !status_line_oe_n_o && !load_done_oe_n_o && chain_enable_out_n_o && !user_mode_o)
      else $error("request low did not hold reset");
   a_done_frees_chain: assert property (
      $rose(load_done_oe_n_o) |-> $fell(chain_enable_out_n_o)) else $error("chain output not with done");
   a_chain_gate: assert property (
      $rose(load_done_oe_n_o) |-> !$past(chain_enable_in_n_i, 3)) else $error("loaded while not enabled");
   a_user_needs_done: assert property (
      $rose(user_mode_o) |-> load_done_i && status_line_i) else $error("user mode without shared done");
   a_init_internal: assert property (
      s_done_seen |-> s_user_entry) else $error("initialization length wrong");
   a_rdata_one_cycle: assert property (
      !$past(reg_rd_i) |-> reg_rdata_o == 32'h0) else $error("read data outside its cycle");
endmodule

bind ps_config_loader ps_config_loader_asserts #(
   .POR_LONG_CYCLES(POR_LONG_CYCLES),
   .POR_SHORT_CYCLES(POR_SHORT_CYCLES)
) u_asserts (
   .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .por_delay_select_i(por_delay_select_i),
   .io_weak_pull_n_i(io_weak_pull_n_i), .config_request_i(config_request_i),
   .chain_enable_in_n_i(chain_enable_in_n_i), .chain_enable_out_n_o(chain_enable_out_n_o),
   .status_line_i(status_line_i), .status_line_oe_n_o(status_line_oe_n_o),
   .load_done_i(load_done_i), .load_done_oe_n_o(load_done_oe_n_o), .user_io_hiz_o(user_io_hiz_o),
   .weak_pull_en_o(weak_pull_en_o), .user_mode_o(user_mode_o), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o)
);

// ### test/cable_host_model.sv
// Host model driving request, serial clock and data like a download cable.
// Assumes open-drain status and done lines with pull-ups, resolved here.
`timescale 1ns/1ns
module cable_host_model (
   input wire logic status_oe_n_i,
   input wire logic status_drv_i,
   input wire logic done_oe_n_i,
   input wire logic done_drv_i,
   input wire logic other_pull_low_i,
   output logic config_request_o,
   output logic serial_clock_o,
   output logic serial_data_o,
   output logic status_line_o,
   output logic load_done_o
);
   // Pull-ups win when released; another chain member may pull status low
   assign status_line_o = (status_oe_n_i ? 1'b1 : status_drv_i) && !other_pull_low_i;
   assign load_done_o = done_oe_n_i ? 1'b1 : done_drv_i;
   // Clock and data idle at pull-up level; request idles low
   initial begin
      config_request_o = 1'b0;
      serial_clock_o = 1'b1;
      serial_data_o = 1'b1;
   end
   // Low pulse then rise starts a new configuration
   task automatic restart();
      #7;
      config_request_o = 1'b0;
      #400;
      config_request_o = 1'b1;
   endtask
   // One word, MSB first, one bit per clock; clock stands still after
   task automatic send(input logic [31:0] w);
      int i;
      #7;
      for (i = 0; i < 400 && !status_line_o; i++) #40;
      if (status_line_o) begin
         for (i = 31; i >= 0 && !load_done_o; i--) begin
            serial_clock_o = 1'b0;
            serial_data_o = w[i];
            #160;
            serial_clock_o = 1'b1;
            #160;
         end
      end
      serial_data_o = 1'b1;
   endtask
endmodule

// ### test/tb_ps_config_loader.sv
// Bench for the loader: power-up, loads, chain, errors and registers.
// Assumes the loader, its checker and the cable host model are compiled.
`timescale 1ns/1ns
module tb_ps_config_loader;
   logic clk_sys_i;
   logic rst_b_i;
   logic por_sel, pull_n, ce_n, other_low, wr_s, rd_s;
   logic [ps_loader_pkg::ADDR_W-1:0] addr;
   logic [31:0] wdata, rdata, word;
   logic req, sclk, sdata, sts, done, sts_oe_n, sts_drv, done_oe_n, done_drv;
   logic ce_out_n, hiz, pull_en, user, irq, word_v;
   int failures;
   int checks;
   int n;
   int words;

   ps_config_loader #(.POR_LONG_CYCLES(50), .POR_SHORT_CYCLES(20)) dut (
      .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .por_delay_select_i(por_sel),
      .io_weak_pull_n_i(pull_n), .config_request_i(req), .serial_config_clock_i(sclk),
      .serial_config_in_i(sdata), .chain_enable_in_n_i(ce_n), .chain_enable_out_n_o(ce_out_n),
      .status_line_i(sts), .status_line_o(sts_drv), .status_line_oe_n_o(sts_oe_n),
      .load_done_i(done), .load_done_o(done_drv), .load_done_oe_n_o(done_oe_n),
      .user_io_hiz_o(hiz), .weak_pull_en_o(pull_en), .user_mode_o(user),
      .config_word_o(word), .config_word_valid_o(word_v), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .irq_o(irq)
   );
   cable_host_model host (
      .status_oe_n_i(sts_oe_n), .status_drv_i(sts_drv), .done_oe_n_i(done_oe_n),
      .done_drv_i(done_drv), .other_pull_low_i(other_low), .config_request_o(req),
      .serial_clock_o(sclk), .serial_data_o(sdata), .status_line_o(sts), .load_done_o(done)
   );
   // 25 MHz system clock
   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end
   // Completed words, counted mid-cycle where the pulse is settled
   always @(negedge clk_sys_i) begin
      if (word_v === 1'b1) begin
         words++;
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic report_and_stop();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Cycle counts; a count out of range ends the run
   task automatic chk_rng(input string what, input int lo, input int hi, input int got);
      checks++;
      if (got < lo || got > hi) begin
         failures++;
         $display("wrong value %s expected %0d to %0d seen %0d", what, lo, hi, got);
         report_and_stop();
      end
   endtask
   task automatic settle(input int c);
      repeat (c) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk_sys_i);
      wr_s <= 1'b0;
   endtask
   task automatic rd_chk(input string what, input logic [4:0] a, input logic [31:0] m, input logic [31:0] exp);
      @(posedge clk_sys_i);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_sys_i);
      rd_s <= 1'b0;
      #1;
      chk(what, exp, rdata & m);
   endtask
   task automatic power_up(input logic sel, input logic pn, input int por);
      @(posedge clk_sys_i);
      rst_b_i <= 1'b0;
      por_sel <= sel;
      pull_n <= pn;
      words = 0;
      fork
         host.restart();
      join_none
      repeat (16) @(posedge clk_sys_i);
      rst_b_i <= 1'b1;
      for (n = 0; n < por + 12 && sts_oe_n !== 1'b1; n++) @(posedge clk_sys_i);
      chk_rng("power-on cycles", por, por + 11, n);
      settle(2);
      chk("status wire", 1, sts);
      chk("weak pulls", {31'h0, !pn}, pull_en);
      chk("io float", 1, hiz);
   endtask
   task automatic load_end(input logic [31:0] w);
      for (n = 0; n < 20 && ce_out_n !== 1'b0; n++) @(posedge clk_sys_i);
      chk_rng("chain release", 0, 19, n);
      chk("done wire", 1, done);
      chk("last word", w, word);
      chk("words taken", 2, words);
      chk("io float", 1, hiz);
      for (n = 0; n < 300 && user !== 1'b1; n++) @(posedge clk_sys_i);
      chk_rng("init cycles", 250, 280, n);
      #1;
      chk("io live", 0, hiz);
   endtask
   // Overall limit on the run
   initial begin
      #3000000;
      failures++;
      report_and_stop();
   end
   // Main sequence
   initial begin
      rst_b_i = 1'b0;
      por_sel = 1'b1;
      pull_n = 1'b0;
      ce_n = 1'b0;
      other_low = 1'b0;
      addr = '0;
      wdata = 32'h0;
      wr_s = 1'b0;
      rd_s = 1'b0;
      failures = 0;
      checks = 0;
      power_up(1'b1, 1'b0, 20);
      wr(ps_loader_pkg::REG_LENGTH, 32'h40);
      rd_chk("state", ps_loader_pkg::REG_STATUS, 32'h7, 32'h2);
      rd_chk("length", ps_loader_pkg::REG_LENGTH, 32'hFFFF_FFFF, 32'h40);
      host.send(ps_loader_pkg::PREAMBLE);
      chk("done early", 0, done);
      host.send(32'h1234_5678);
      load_end(32'h1234_5678);
      // Interrupt raised, masked and cleared
      wr(ps_loader_pkg::REG_IRQ_MASK, 32'hF);
      settle(2);
      chk("irq raised", 1, irq);
      rd_chk("events", ps_loader_pkg::REG_IRQ_STAT, 32'hF, 32'hB);
      wr(ps_loader_pkg::REG_IRQ_MASK, 32'h0);
      settle(2);
      chk("irq masked", 0, irq);
      wr(ps_loader_pkg::REG_IRQ_STAT, 32'hF);
      rd_chk("events cleared", ps_loader_pkg::REG_IRQ_STAT, 32'hF, 32'h0);
      wr(ps_loader_pkg::REG_STATUS, 32'h0);
      rd_chk("user state", ps_loader_pkg::REG_STATUS, 32'h7, 32'h5);
      rd_chk("unmapped", 5'h1C, 32'hFFFF_FFFF, 32'h0);
      // Long power-on, chain disabled, bad stream, restart
      ce_n <= 1'b1;
      power_up(1'b0, 1'b1, 50);
      rd_chk("length reset", ps_loader_pkg::REG_LENGTH, 32'hFFFF_FFFF, ps_loader_pkg::LENGTH_RST);
      rd_chk("mask reset", ps_loader_pkg::REG_IRQ_MASK, 32'hF, {28'h0, ps_loader_pkg::IRQ_MASK_RST});
      wr(ps_loader_pkg::REG_LENGTH, 32'h40);
      host.send(ps_loader_pkg::PREAMBLE);
      host.send(32'h1234_5678);
      settle(8);
      chk("done held", 0, done_oe_n);
      rd_chk("bits taken", ps_loader_pkg::REG_BIT_COUNT, 32'hFFFF_FFFF, 32'h0);
      ce_n <= 1'b0;
      host.send(32'hDEAD_BEEF);
      settle(8);
      chk("status pulled", 0, sts);
      chk("words in error", 1, words);
      rd_chk("error state", ps_loader_pkg::REG_STATUS, 32'h17, 32'h16);
      host.restart();
      for (n = 0; n < 40 && sts_oe_n !== 1'b1; n++) @(posedge clk_sys_i);
      chk_rng("restart release", 0, 39, n);
      settle(4);
      rd_chk("config again", ps_loader_pkg::REG_STATUS, 32'h7, 32'h2);
      other_low <= 1'b1;
      settle(8);
      rd_chk("held by chain", ps_loader_pkg::REG_STATUS, 32'h7, 32'h1);
      other_low <= 1'b0;
      settle(8);
      rd_chk("config resumed", ps_loader_pkg::REG_STATUS, 32'h7, 32'h2);
      words = 0;
      host.send(ps_loader_pkg::PREAMBLE);
      host.send(32'hC3C3_0F0F);
      load_end(32'hC3C3_0F0F);
      report_and_stop();
   end
endmodule
